// [verilog/ccs_pkg.sv]
package ccs_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int INSTR_W = 16;
    localparam int BANK_W = 4;
    localparam int REG_AW = 3;

    // ****************************************
    // Opcodes and addressing
    // ****************************************
    localparam logic [5:0] OPC_INVERT = 6'h07;
    localparam logic [6:0] OPC_CMPEQ = 7'h31;
    localparam logic [7:0] ILO_MAX = 8'h5F;
    localparam logic [ADDR_W-1:0] ACC_LO_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] ACC_HI_BASE = 12'hF00;

    // Instruction field positions
    localparam int F_LSB = 0;
    localparam int F_MSB = 7;
    localparam int A_BIT = 8;
    localparam int D_BIT = 9;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [REG_AW-1:0] REG_WORK = 3'h0;
    localparam logic [REG_AW-1:0] REG_STATUS = 3'h1;
    localparam logic [REG_AW-1:0] REG_BANK = 3'h2;
    localparam logic [REG_AW-1:0] REG_CTRL = 3'h3;
    localparam logic [REG_AW-1:0] REG_IDX_LO = 3'h4;
    localparam logic [REG_AW-1:0] REG_IDX_HI = 3'h5;
    localparam logic [REG_AW-1:0] REG_EXEC = 3'h6;

    localparam int ST_Z_BIT = 0;
    localparam int ST_N_BIT = 1;
    localparam int CTRL_EXT_BIT = 0;
    localparam int EXEC_SKIP_BIT = 0;
    localparam int EXEC_TWO_BIT = 1;

    localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
    localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
    localparam logic [ADDR_W-1:0] IDX_RST = 12'h000;

    // ****************************************
    // Quarter cycles
    // ****************************************
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;
    localparam int QDIV_DEF = 4;

    typedef enum logic [0:0] {EX_RUN, EX_SKIP} ccs_fsm_t;

endpackage

// [verilog/ccs_q_if.sv]
`timescale 1ns/1ns
interface ccs_q_if;
    logic tick;
    logic [1:0] phase;
    modport src (output tick, output phase);
    modport snk (input tick, input phase);
endinterface

// [verilog/ccs_qgen.sv]
`timescale 1ns/1ns
module ccs_qgen
    import ccs_pkg::*;
#(
    parameter int QDIV = QDIV_DEF
)
(
    input wire logic ref_clk_in, // Core clock
    input wire logic rst_in,     // Sync reset, high
    ccs_q_if.src q_out           // Quarter tick and phase
);
    localparam int CW = (QDIV > 1) ? $clog2(QDIV) : 1;
    localparam logic [CW-1:0] CNT_TOP = CW'(QDIV - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [1:0] q;
        logic tick;
    } ccs_qstate_t;

    ccs_qstate_t st;
    ccs_qstate_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt == CNT_TOP)
        begin
            next_st.cnt = CNT_ZERO;
            next_st.tick = 1'b1;
            next_st.q = st.q + 2'h1;
        end
        else
        begin
            next_st.cnt = st.cnt + CW'(1);
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            st.cnt <= CNT_ZERO;
            // First tick after reset lands on Q1
            st.q <= Q4;
            st.tick <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign q_out.tick = st.tick;
    assign q_out.phase = st.q;

endmodule

// [verilog/ccs_exec.sv]
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ns

module ccs_exec
    import ccs_pkg::*;
#(
    parameter int QDIV = QDIV_DEF
)
(
    input wire logic ref_clk_in,                 // Core clock
    input wire logic rst_in,                     // Sync reset, high
    input wire logic [INSTR_W-1:0] instr_in,     // Fetched instruction word
    input wire logic instr_valid_in,             // Fetched word present
    input wire logic instr_two_word_in,          // Fetched word opens 2-word op
    output logic instr_take_out,                 // Word taken at Q1
    output logic instr_discard_out,              // Taken word is discarded
    output logic [ADDR_W-1:0] mem_addr_out,      // Data memory address
    output logic mem_rd_out,                     // Data memory read pulse
    input wire logic [DATA_W-1:0] mem_rdata_in,  // Read data, next cycle
    output logic mem_we_out,                     // Data memory write pulse
    output logic [DATA_W-1:0] mem_wdata_out,     // Data memory write data
    output logic skip_out,                       // No-op cycle in progress
    input wire logic [REG_AW-1:0] reg_addr_in,   // Register address
    input wire logic [DATA_W-1:0] reg_wdata_in,  // Register write data
    input wire logic reg_wr_in,                  // Register write strobe
    input wire logic reg_rd_in,                  // Register read strobe
    output logic [DATA_W-1:0] reg_rdata_out      // Read data, next cycle
);

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic is_invert(input logic [INSTR_W-1:0] iw);
        return iw[INSTR_W-1:D_BIT+1] == OPC_INVERT;
    endfunction

    function automatic logic is_cmpeq(input logic [INSTR_W-1:0] iw);
        return iw[INSTR_W-1:A_BIT+1] == OPC_CMPEQ;
    endfunction

    function automatic logic [ADDR_W-1:0] ea(input logic [INSTR_W-1:0] iw,
                                              input logic ext,
                                              input logic [BANK_W-1:0] bank,
                                              input logic [ADDR_W-1:0] idx);
        logic [7:0] f;
        f = iw[F_MSB:F_LSB];
        if (iw[A_BIT])
            return {bank, f};
        else if (ext && f <= ILO_MAX)
            return idx + {4'h0, f};
        else if (f <= ILO_MAX)
            return ACC_LO_BASE | {4'h0, f};
        else
            return ACC_HI_BASE | {4'h0, f};
    endfunction

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        ccs_fsm_t fsm;
        logic [1:0] skip_left;
        logic skip_first;
        logic two_word;
        logic op_inv;
        logic op_cmp;
        logic dest_f;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] operand;
        logic [DATA_W-1:0] result;
        logic equal;
        logic [DATA_W-1:0] work;
        logic flag_n;
        logic flag_z;
        logic [BANK_W-1:0] bank;
        logic ext_en;
        logic [ADDR_W-1:0] idx;
        logic [DATA_W-1:0] rdata;
        logic mem_rd;
        logic mem_we;
        logic [DATA_W-1:0] wdata;
    } ccs_state_t;

    ccs_state_t st;
    ccs_state_t next_st;
    ccs_q_if q_bus();

    ccs_qgen #(
        .QDIV(QDIV)
    ) u_qgen (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .q_out(q_bus)
    );

    logic q1;
    logic q2;
    logic q3;
    logic q4;
    assign q1 = q_bus.tick && (q_bus.phase == Q1);
    assign q2 = q_bus.tick && (q_bus.phase == Q2);
    assign q3 = q_bus.tick && (q_bus.phase == Q3);
    assign q4 = q_bus.tick && (q_bus.phase == Q4);

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        next_st = st;
        next_st.mem_rd = 1'b0;
        next_st.mem_we = 1'b0;

        // Software writes first so execution wins a same-cycle clash
        if (reg_wr_in)
        begin
            case (reg_addr_in)
                REG_WORK: next_st.work = reg_wdata_in;
                REG_STATUS:
                begin
                    next_st.flag_n = reg_wdata_in[ST_N_BIT];
                    next_st.flag_z = reg_wdata_in[ST_Z_BIT];
                end
                REG_BANK: next_st.bank = reg_wdata_in[BANK_W-1:0];
                REG_CTRL: next_st.ext_en = reg_wdata_in[CTRL_EXT_BIT];
                REG_IDX_LO: next_st.idx[DATA_W-1:0] = reg_wdata_in;
                REG_IDX_HI: next_st.idx[ADDR_W-1:DATA_W] = reg_wdata_in[ADDR_W-DATA_W-1:0];
                default: ;
            endcase
        end

        if (reg_rd_in)
        begin
            case (reg_addr_in)
                REG_WORK: next_st.rdata = st.work;
                REG_STATUS:
                begin
                    next_st.rdata = '0;
                    next_st.rdata[ST_N_BIT] = st.flag_n;
                    next_st.rdata[ST_Z_BIT] = st.flag_z;
                end
                REG_BANK: next_st.rdata = {4'h0, st.bank};
                REG_CTRL: next_st.rdata = {7'h00, st.ext_en};
                REG_IDX_LO: next_st.rdata = st.idx[DATA_W-1:0];
                REG_IDX_HI: next_st.rdata = {4'h0, st.idx[ADDR_W-1:DATA_W]};
                REG_EXEC:
                begin
                    next_st.rdata = '0;
                    next_st.rdata[EXEC_SKIP_BIT] = (st.fsm == EX_SKIP);
                    next_st.rdata[EXEC_TWO_BIT] = st.two_word;
                end
                default: next_st.rdata = '0;
            endcase
        end

        case (st.fsm)
            EX_RUN:
            begin
                if (q1)
                begin
                    // Unknown opcodes pass through as no-ops here
                    next_st.op_inv = instr_valid_in && is_invert(instr_in);
                    next_st.op_cmp = instr_valid_in && is_cmpeq(instr_in);
                    next_st.dest_f = instr_in[D_BIT];
                    next_st.addr = ea(instr_in, st.ext_en, st.bank, st.idx);
                end
                if (q2 && (st.op_inv || st.op_cmp))
                begin
                    next_st.mem_rd = 1'b1;
                end
                if (q3)
                begin
                    next_st.operand = mem_rdata_in;
                    next_st.result = ~mem_rdata_in;
                    // Unsigned subtraction, result used only for equality
                    next_st.equal = (mem_rdata_in - st.work) == '0;
                end
                if (q4 && st.op_inv)
                begin
                    next_st.flag_n = st.result[DATA_W-1];
                    next_st.flag_z = (st.result == '0);
                    if (st.dest_f)
                    begin
                        next_st.mem_we = 1'b1;
                        next_st.wdata = st.result;
                    end
                    else
                    begin
                        next_st.work = st.result;
                    end
                end
                if (q4 && st.op_cmp && st.equal)
                begin
                    next_st.fsm = EX_SKIP;
                    next_st.skip_left = 2'h1;
                    next_st.skip_first = 1'b1;
                    next_st.two_word = 1'b0;
                end
                if (q4)
                begin
                    next_st.op_inv = 1'b0;
                    next_st.op_cmp = 1'b0;
                end
            end
            EX_SKIP:
            begin
                if (q1 && st.skip_first)
                begin
                    next_st.skip_first = 1'b0;
                    if (instr_two_word_in)
                    begin
                        next_st.skip_left = 2'h2;
                        next_st.two_word = 1'b1;
                    end
                end
                if (q4)
                begin
                    next_st.skip_left = st.skip_left - 2'h1;
                    if (st.skip_left == 2'h1)
                    begin
                        next_st.fsm = EX_RUN;
                        next_st.two_word = 1'b0;
                    end
                end
            end
            default: next_st.fsm = EX_RUN;
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            st <= '0;
            st.fsm <= EX_RUN;
            st.work <= WORK_RST;
            st.bank <= BANK_RST;
            st.idx <= IDX_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign instr_take_out = q1 && instr_valid_in;
    // Discarded word still counts as taken so fetch advances past it
    assign instr_discard_out = q1 && instr_valid_in && (st.fsm == EX_SKIP);
    assign mem_addr_out = st.addr;
    assign mem_rd_out = st.mem_rd;
    assign mem_we_out = st.mem_we;
    assign mem_wdata_out = st.wdata;
    assign skip_out = (st.fsm == EX_SKIP);
    assign reg_rdata_out = st.rdata;

endmodule

// [tb/ccs_exec_sva.sv]
`timescale 1ns/1ns
module ccs_exec_sva
    import ccs_pkg::*;
#(
    parameter int QDIV = QDIV_DEF
)
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [INSTR_W-1:0] instr_in,
    input wire logic instr_valid_in,
    input wire logic instr_take_out,
    input wire logic instr_discard_out,
    input wire logic mem_rd_out,
    input wire logic [DATA_W-1:0] mem_rdata_in,
    input wire logic mem_we_out,
    input wire logic [DATA_W-1:0] mem_wdata_out,
    input wire logic skip_out
);
    // ****
    // Decoded takes and skip run length
    // ****
    localparam int CYC = 4*QDIV;
    localparam int RD_D = QDIV+1;
    localparam int WE_D = 3*QDIV+1;
    logic go, inv, inv_wb, cmp;
    logic [7:0] run;
    // Discarded words are taken too, so they must not count as work
    assign go = instr_take_out && !instr_discard_out;
    assign inv = go && instr_in[15:10] == OPC_INVERT;
    assign inv_wb = inv && instr_in[D_BIT];
    assign cmp = go && instr_in[15:9] == OPC_CMPEQ;
    always_ff @(posedge ref_clk_in)
    begin
        run <= (rst_in || !skip_out) ? 8'h00 : run + 8'h01;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    a_discard_take: assert property (instr_discard_out |-> instr_take_out && skip_out)
        else $error("discard outside a skip take");
    a_take_valid: assert property (instr_take_out |-> instr_valid_in)
        else $error("take without valid word");
    a_invert_read: assert property (inv |-> ##RD_D mem_rd_out)
        else $error("invert read not in second quarter");
    a_read_cause: assert property (mem_rd_out |-> $past(go, RD_D))
        else $error("memory read without instruction");
    a_write_back: assert property (inv_wb |-> ##WE_D mem_we_out)
        else $error("write back missing");
    a_write_cause: assert property (mem_we_out |-> $past(inv_wb, WE_D))
        else $error("memory write without invert to register");
    a_write_data: assert property (mem_we_out |-> mem_wdata_out == ~$past(mem_rdata_in, RD_D))
        else $error("write data not inverted read data");
    a_skip_len: assert property ($fell(skip_out) |-> run == CYC || run == 2*CYC)
        else $error("skip length wrong");
    a_skip_cause: assert property ($rose(skip_out) |-> $past(cmp, WE_D))
        else $error("skip without compare");
    c_two_skip: cover property ($fell(skip_out) && run == 2*CYC);
    c_write: cover property (mem_we_out);
    c_discard: cover property (instr_discard_out);
endmodule

bind ccs_exec ccs_exec_sva #(.QDIV(QDIV)) ccs_exec_sva_inst (.ref_clk_in, .rst_in, .instr_in,
    .instr_valid_in, .instr_take_out, .instr_discard_out, .mem_rd_out, .mem_rdata_in,
    .mem_we_out, .mem_wdata_out, .skip_out);

// [tb/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
    import ccs_pkg::*;
    // ****
    // Stimulus and memory
    // ****
    localparam int QD = 2;
    localparam int CYC = 4*QD;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [15:0] instr_in = 16'h0000;
    logic instr_valid_in = 1'b1;
    logic instr_two_word_in = 1'b0;
    logic instr_take_out, instr_discard_out, mem_rd_out, mem_we_out, skip_out;
    logic [11:0] mem_addr_out;
    logic [7:0] mem_rdata_in, mem_wdata_out, reg_rdata_out;
    logic [2:0] reg_addr_in = 3'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] mem [0:4095];
    // Fields: ext, access, operand, expected address
    logic [21:0] tab [6] = '{22'h010010, 22'h080F80, 22'h210133, 22'h25F182, 22'h260F60,
        22'h310310};
    int n_errors = 0;
    int total_checks = 0;
    int skip_cnt = 0;
    int disc_cnt = 0;
    always #2 ref_clk_in = ~ref_clk_in;
    assign mem_rdata_in = mem[mem_addr_out];
    // Counters by NBA so reads at the edge see settled values
    always @(posedge ref_clk_in)
    begin
        if (mem_we_out === 1'b1)
            mem[mem_addr_out] <= mem_wdata_out;
        if (skip_out === 1'b1)
            skip_cnt <= skip_cnt + 1;
        if (instr_discard_out === 1'b1)
            disc_cnt <= disc_cnt + 1;
    end
    ccs_exec #(.QDIV(QD)) ccs_exec_inst (.ref_clk_in, .rst_in, .instr_in, .instr_valid_in,
        .instr_two_word_in, .instr_take_out, .instr_discard_out, .mem_addr_out, .mem_rd_out,
        .mem_rdata_in, .mem_we_out, .mem_wdata_out, .skip_out, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out);
    // ****
    // Tasks
    // ****
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic summarize;
        if (n_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk($sformatf("reg%0d", a), {8'h00, e}, {8'h00, reg_rdata_out});
    endtask
    // Word stays until taken at a Q1, then a no-op opcode follows
    task automatic exec(input logic [15:0] ins);
        int k;
        k = 0;
        @(posedge ref_clk_in);
        instr_in <= ins;
        @(posedge ref_clk_in);
        while (instr_take_out !== 1'b1 && k < 4*CYC)
        begin
            @(posedge ref_clk_in);
            k++;
        end
        if (instr_take_out !== 1'b1)
        begin
            chk("take", 16'h0001, {15'h0000, instr_take_out});
            summarize();
        end
        instr_in <= 16'h0000;
        // Stop short of the next Q1: write landed, address not yet reloaded
        repeat (CYC - 1) @(posedge ref_clk_in);
        #1;
    endtask
    // ****
    // Sequence
    // ****
    initial
    begin
        logic [7:0] r;
        int s0, d0;
        for (int i = 0; i < 4096; i++)
            mem[i] = 8'(i) ^ 8'hA5;
        mem[12'h345] = 8'h13;
        mem[12'hF80] = 8'hFF;
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd(3'(i), 8'h00);
        wr(REG_BANK, 8'h03);
        wr(REG_WORK, 8'h5A);
        exec({OPC_INVERT, 2'b11, 8'h45});
        chk("addr", 16'h0345, {4'h0, mem_addr_out});
        chk("mem", 16'h00EC, {8'h00, mem[12'h345]});
        rd(REG_WORK, 8'h5A);
        rd(REG_STATUS, 8'h02);
        wr(REG_IDX_LO, 8'h23);
        wr(REG_IDX_HI, 8'h01);
        for (int i = 0; i < 6; i++)
        begin
            wr(REG_CTRL, {7'h00, tab[i][21]});
            exec({OPC_INVERT, 1'b0, tab[i][20:12]});
            chk("addr", {4'h0, tab[i][11:0]}, {4'h0, mem_addr_out});
            r = ~mem[tab[i][11:0]];
            rd(REG_WORK, r);
            rd(REG_STATUS, {6'h00, r[7], r == 8'h00});
        end
        wr(REG_STATUS, 8'h03);
        for (int i = 0; i < 3; i++)
        begin
            mem[12'h310] = (i == 0) ? 8'h66 : 8'h77;
            wr(REG_WORK, 8'h77);
            instr_two_word_in <= (i == 2);
            s0 = skip_cnt;
            d0 = disc_cnt;
            exec({OPC_CMPEQ, 1'b1, 8'h10});
            rd(REG_EXEC, {6'h00, i == 2, i != 0});
            repeat (3*CYC) @(posedge ref_clk_in);
            chk("skip", 16'(CYC * i), 16'(skip_cnt - s0));
            chk("discard", 16'(i), 16'(disc_cnt - d0));
            rd(REG_WORK, 8'h77);
            rd(REG_STATUS, 8'h03);
        end
        summarize();
    end
endmodule
